/* File: acb_core_model.sv */
// Model of the analog core and its master clock source.
// Assumes clk is the system clock; the master clock idles low between conversions.
`timescale 1ns/10ps
module acb_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Status and core outputs
	input wire logic busy,
	output logic conversion_master_clock,
	output acb_pkg::acb_result_s core_result
);
	int seed = 85;
	// The code only moves while idle, so a held sample never changes under the port.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conversion_master_clock <= 1'b0;
			core_result <= '0;
		end else begin
			conversion_master_clock <= busy && !conversion_master_clock;
			if (!busy) begin
				core_result <= 15'($random(seed));
			end
		end
	end
endmodule // acb_core_model

/* File: acb_pkg.sv */
// Package for the converter control and byte-wide parallel port block.
// Assumes a single 20 MHz system clock; the converter master clock arrives as a synchronous input.
package acb_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int CHAN_W = 3;
	localparam int WORD_W = 16;
	localparam int CONV_CYCLES_12 = 12;
	localparam int CONV_CYCLES_10 = 10;
	localparam logic [3:0] CONV_CNT_W4_12 = 4'hC;
	localparam logic [3:0] CONV_CNT_W4_10 = 4'hA;

	// ----------------------------------------------------------------
	// Field positions in the byte port
	// ----------------------------------------------------------------
	localparam int HI_DATA_LSB = 0;
	localparam int HI_ID_LSB = 4;
	localparam int RES10_SHIFT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] SHADOW_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACB_IDLE,
		ACB_CONV,
		ACB_DONE
	} acb_state_e;

	// Bus strobes from the processor side; cs_n, rd_n and wr_n are active low, byte_half_select high picks the high byte.
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic byte_half_select;
	} acb_bus_s;

	// Result handed in by the analog converter core.
	typedef struct packed {
		logic [11:0] code;
		logic [2:0] chan;
	} acb_result_s;

endpackage

/* File: acb_port.sv */
// Conversion control and byte-wide tri-state port of an eight-channel converter.
// Assumes all inputs are synchronous to clk; the analog core supplies its result code and channel.
`timescale 1ns/10ps

// Functional notes
// - Low half select puts low byte on lines.
// - Ten-bit low byte: two zero LSBs, data.
// - High half: upper four bits on lines 0-3.
// - High byte read carries channel id bits 4-5.
// - Data lines tri-state, read results, write registers.
// - Busy rises after trigger fall, holds conversion.
// - Busy falls after result loads output register.
// - Track resumes just before busy falls.
// - Conversion lasts 12 or 10 master clocks.
// - Trigger fall switches to hold, starts conversion.
// - Trigger rise powers up from automatic low power.
// - Drive result when chip select and read low.
module acb_port #(
	parameter int RES_BITS = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Processor bus
	input wire acb_pkg::acb_bus_s bus,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	// Conversion control pins
	input wire logic conversion_trigger,
	input wire logic conversion_master_clock,
	output logic busy,
	// Power state request from control logic
	input wire logic auto_standby,
	output logic powered_up,
	// Analog core
	input wire acb_pkg::acb_result_s core_result,
	output logic track_hold_n,
	output logic [15:0] ctrl_word,
	output logic [15:0] shadow_word
);

	// Only the two resolutions below have a conversion length and a byte layout.
	if (RES_BITS != 12 && RES_BITS != 10) begin : g_res_check
		$error("RES_BITS must be 12 or 10");
	end

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;

	// Release is delayed two clocks so no flop leaves reset on a metastable edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Edge detection of inputs
	// ----------------------------------------------------------------
	logic trig_d_reg;
	logic mclk_d_reg;
	logic wr_d_reg;
	logic trig_fall;
	logic trig_rise;
	logic mclk_rise;
	logic wr_rise;
	logic [2:0] edge_next;

	always_comb begin
		edge_next = {conversion_trigger, conversion_master_clock, bus.wr_n | bus.cs_n};
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			trig_d_reg <= 1'b1;
			mclk_d_reg <= 1'b0;
			wr_d_reg <= 1'b1;
		end else begin
			{trig_d_reg, mclk_d_reg, wr_d_reg} <= edge_next;
		end
	end

	assign trig_fall = trig_d_reg & ~conversion_trigger;
	assign trig_rise = ~trig_d_reg & conversion_trigger;
	assign mclk_rise = ~mclk_d_reg & conversion_master_clock;
	// A write commits on the first clock that sees the combined strobe low. A longer strobe
	// must not commit again, or one high write would land in both registers.
	assign wr_rise = wr_d_reg & ~(bus.wr_n | bus.cs_n);

	// ----------------------------------------------------------------
	// Conversion state machine
	// ----------------------------------------------------------------
	localparam logic [3:0] CONV_LEN = (RES_BITS == 12) ? acb_pkg::CONV_CNT_W4_12 : acb_pkg::CONV_CNT_W4_10;

	acb_pkg::acb_state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [11:0] result_reg, result_next;
	logic [2:0] chan_reg, chan_next;
	logic busy_reg, busy_next;
	logic hold_reg, hold_next;
	logic power_reg, power_next;

	// Busy and hold follow the state; the result lands before busy drops.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		result_next = result_reg;
		chan_next = chan_reg;
		busy_next = busy_reg;
		hold_next = hold_reg;
		power_next = power_reg;
		if (trig_rise) begin
			power_next = 1'b1;
		end else if (auto_standby && state_reg == acb_pkg::ACB_IDLE && !trig_fall) begin
			power_next = 1'b0;
		end
		unique case (state_reg)
			acb_pkg::ACB_IDLE: begin
				// A trigger fall during a conversion is ignored; the controller must wait.
				if (trig_fall) begin
					state_next = acb_pkg::ACB_CONV;
					cnt_next = 4'h0;
					hold_next = 1'b1;
					busy_next = 1'b1;
				end
			end
			acb_pkg::ACB_CONV: begin
				if (mclk_rise) begin
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg + 4'h1 == CONV_LEN) begin
						result_next = core_result.code;
						chan_next = core_result.chan;
						hold_next = 1'b0;
						state_next = acb_pkg::ACB_DONE;
					end
				end
			end
			acb_pkg::ACB_DONE: begin
				// Busy drops one clock after the output register loads.
				busy_next = 1'b0;
				state_next = acb_pkg::ACB_IDLE;
			end
			default: begin
				state_next = acb_pkg::ACB_IDLE;
				busy_next = 1'b0;
				hold_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg <= acb_pkg::ACB_IDLE;
			cnt_reg <= 4'h0;
			result_reg <= acb_pkg::RESULT_RST;
			chan_reg <= 3'h0;
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
			power_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			result_reg <= result_next;
			chan_reg <= chan_next;
			busy_reg <= busy_next;
			hold_reg <= hold_next;
			power_reg <= power_next;
		end
	end

	assign busy = busy_reg;
	assign track_hold_n = ~hold_reg;
	assign powered_up = power_reg;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] shadow_reg, shadow_next;
	logic [7:0] low_latch_reg, low_latch_next;
	logic shadow_sel_reg, shadow_sel_next;

	// Low byte is staged; the high write commits the full word. Control bit 0 routes
	// the following word to the shadow register, a small stand-in for the full map.
	always_comb begin
		ctrl_next = ctrl_reg;
		shadow_next = shadow_reg;
		low_latch_next = low_latch_reg;
		shadow_sel_next = shadow_sel_reg;
		if (wr_rise) begin
			if (!bus.byte_half_select) begin
				low_latch_next = data_lines_in;
			end else if (shadow_sel_reg) begin
				shadow_next = {4'h0, data_lines_in[3:0], low_latch_reg};
				shadow_sel_next = 1'b0;
			end else begin
				ctrl_next = {4'h0, data_lines_in[3:0], low_latch_reg};
				shadow_sel_next = low_latch_reg[0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ctrl_reg <= acb_pkg::CTRL_RST;
			shadow_reg <= acb_pkg::SHADOW_RST;
			low_latch_reg <= 8'h00;
			shadow_sel_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			shadow_reg <= shadow_next;
			low_latch_reg <= low_latch_next;
			shadow_sel_reg <= shadow_sel_next;
		end
	end

	assign ctrl_word = ctrl_reg;
	assign shadow_word = shadow_reg;

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------
	logic [7:0] rd_data_reg, rd_data_next;
	logic oe_reg, oe_next;

	// Output data is registered, so it appears one clock after both strobes are low.
	always_comb begin
		oe_next = ~bus.cs_n & ~bus.rd_n & bus.wr_n;
		if (bus.byte_half_select) begin
			rd_data_next = {2'b00, chan_reg[1:0], result_reg[11:8]};
		end else if (RES_BITS == 10) begin
			// The high byte already carries bits 11 to 8, so the low byte holds the six below.
			rd_data_next = {result_reg[7:2], 2'b00};
		end else begin
			rd_data_next = result_reg[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rd_data_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			oe_reg <= oe_next;
		end
	end

	assign data_lines_out = rd_data_reg;
	assign data_lines_oe = oe_reg;

endmodule // acb_port

/* File: acb_port_asserts.sv */
// Checker for acb_port: conversion timing and byte lanes.
// Assumes it is bound to acb_port and sees its ports only.
`timescale 1ns/10ps
module acb_port_chk #(
	parameter int RES_BITS = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire acb_pkg::acb_bus_s bus,
	input wire logic [7:0] data_lines_in,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic conversion_trigger,
	input wire logic conversion_master_clock,
	input wire logic busy,
	input wire acb_pkg::acb_result_s core_result,
	input wire logic track_hold_n,
	input wire logic [15:0] ctrl_word,
	input wire logic [15:0] shadow_word
);
	logic mck_reg, mck_next, wr_reg, wr_next, rd_go, sel_reg, sel_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] low_reg, low_next, lo_exp;
	acb_pkg::acb_result_s res_reg, res_next;
	// Count master clock rises in hold; the result is copied one clock after the port loads it.
	always_comb begin
		mck_next = conversion_master_clock;
		wr_next = !bus.cs_n && !bus.wr_n;
		rd_go = !bus.cs_n && !bus.rd_n && bus.wr_n;
		cnt_next = busy ? cnt_reg + 4'(conversion_master_clock && !mck_reg && !track_hold_n) : 4'h0;
		low_next = (wr_next && !wr_reg && !bus.byte_half_select) ? data_lines_in : low_reg;
		res_next = (track_hold_n && busy) ? core_result : res_reg;
		lo_exp = (RES_BITS == 10) ? {res_reg.code[7:2], 2'b00} : res_reg.code[7:0];
		// A high write to the control word with low bit 0 set sends the next word to the shadow.
		sel_next = (wr_next && !wr_reg && bus.byte_half_select) ? (!sel_reg && low_reg[0]) : sel_reg;
	end
	// Helper registers, cleared with the port.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mck_reg <= 1'b0;
			wr_reg <= 1'b0;
			cnt_reg <= 4'h0;
			low_reg <= 8'h00;
			res_reg <= '0;
			sel_reg <= 1'b0;
		end else begin
			mck_reg <= mck_next;
			wr_reg <= wr_next;
			cnt_reg <= cnt_next;
			low_reg <= low_next;
			res_reg <= res_next;
			sel_reg <= sel_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_start_hold: assert property (
		!busy && $fell(conversion_trigger) |=> busy && !track_hold_n) else $error("no hold after trigger fall");
	a_busy_stays: assert property (
		busy && !track_hold_n |=> busy) else $error("busy dropped in hold");
	a_track_first: assert property (
		$fell(busy) |-> $past(track_hold_n) && !$past(track_hold_n, 2)) else $error("track not just before busy");
	a_conv_len: assert property (
		$fell(busy) |-> cnt_reg == 4'(RES_BITS == 10 ? 10 : 12)) else $error("wrong conversion length");
	a_drive_read: assert property (
		rd_go |=> data_lines_oe) else $error("read not driven");
	a_bus_release: assert property (
		(bus.cs_n || bus.rd_n) [*2] |-> !data_lines_oe) else $error("bus not released");
	a_low_byte: assert property (
		rd_go && !bus.byte_half_select |=> data_lines_out == lo_exp) else $error("low byte wrong");
	a_high_byte: assert property (
		rd_go && bus.byte_half_select |=> data_lines_out == {2'b00, res_reg.chan[1:0], res_reg.code[11:8]})
		else $error("high byte wrong");
	a_write_word: assert property (
		wr_next && !wr_reg && bus.byte_half_select && !sel_reg
		|=> ctrl_word == {4'h0, $past(data_lines_in[3:0]), low_reg}) else $error("control word wrong");
	a_shadow_word: assert property (
		wr_next && !wr_reg && bus.byte_half_select && sel_reg
		|=> shadow_word == {4'h0, $past(data_lines_in[3:0]), low_reg} && $stable(ctrl_word))
		else $error("shadow word wrong");
	c_conv: cover property ($fell(busy));
	c_read_hi: cover property (rd_go && bus.byte_half_select);
	c_write_hi: cover property (wr_next && bus.byte_half_select);
	c_write_shadow: cover property (wr_next && !wr_reg && bus.byte_half_select && sel_reg);
endmodule // acb_port_chk

bind acb_port acb_port_chk #(.RES_BITS(RES_BITS)) i_acb_port_chk (.clk, .rst_n, .bus, .data_lines_in,
	.data_lines_out, .data_lines_oe, .conversion_trigger, .conversion_master_clock, .busy, .core_result,
	.track_hold_n, .ctrl_word, .shadow_word);

/* File: acb_port_bench.sv */
// Self-checking bench for acb_port with the core model beside it.
// Assumes a 50 ns clock and no other traffic on the byte bus.
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("Error %0t %h %h", $time, a, b); end end
module acb_port_bench;
	logic clk, rst_n, oe, trig, busy, stby, pwr, mclk, thn;
	logic [7:0] host_d, dout, dbus, lo, hi, exp_v, exp2_v, dout2, dbus2;
	logic [7:0] exp_q[$];
	logic [7:0] exp2_q[$];
	logic [15:0] ctrl, shadow, ctrl2, shadow2;
	logic oe2, busy2, mclk2;
	acb_pkg::acb_bus_s bus;
	acb_pkg::acb_result_s core, r, core2, r2;
	int checks = 0, n_fail = 0, seed = 85;
	// A released bus shows the inverse of the last host value.
	assign dbus = oe ? dout : host_d;
	assign dbus2 = oe2 ? dout2 : host_d;
	acb_port #(.RES_BITS(12)) i_acb_port (.clk(clk), .rst_n(rst_n), .bus(bus), .data_lines_in(dbus),
		.data_lines_out(dout), .data_lines_oe(oe), .conversion_trigger(trig), .conversion_master_clock(mclk),
		.busy(busy), .auto_standby(stby), .powered_up(pwr), .core_result(core), .track_hold_n(thn),
		.ctrl_word(ctrl), .shadow_word(shadow));
	acb_core_model i_acb_core_model (.clk(clk), .rst_n(rst_n), .busy(busy), .conversion_master_clock(mclk),
		.core_result(core));
	// A ten-bit port shares the bus strobes, trigger and standby pins, so the short conversion and its byte layout run too.
	acb_port #(.RES_BITS(10)) i_acb_port_w10 (.clk(clk), .rst_n(rst_n), .bus(bus), .data_lines_in(dbus2),
		.data_lines_out(dout2), .data_lines_oe(oe2), .conversion_trigger(trig), .conversion_master_clock(mclk2),
		.busy(busy2), .auto_standby(stby), .powered_up(), .core_result(core2), .track_hold_n(),
		.ctrl_word(ctrl2), .shadow_word(shadow2));
	acb_core_model i_acb_core_model_w10 (.clk(clk), .rst_n(rst_n), .busy(busy2), .conversion_master_clock(mclk2),
		.core_result(core2));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One bus access; the bus control holds until the port has sampled it.
	task automatic acc(logic w, logic h, logic [7:0] d);
		bus = {1'b0, w, !w, h};
		host_d = d;
		if (!w) exp_q.push_back(d);
		tick(2);
		bus = 4'hE;
		host_d = ~d;
		tick(3);
	endtask
	// Conversion, optionally with a second fall while busy that must be ignored.
	task automatic conv(logic again);
		trig = 1'b0;
		tick(3);
		r = core;
		r2 = core2;
		trig = 1'b1;
		tick(1);
		trig = !again;
		tick(1);
		trig = 1'b1;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
		`CHK(busy, 1'b0)
		`CHK(busy2, 1'b0)
		exp2_q.push_back({r2.code[7:2], 2'b00});
		exp2_q.push_back({2'b00, r2.chan[1:0], r2.code[11:8]});
		acc(1'b0, 1'b0, r.code[7:0]);
		acc(1'b0, 1'b1, {2'b00, r.chan[1:0], r.code[11:8]});
	endtask
	// Each new read answer is checked against the oldest note.
	always @(posedge clk) begin
		if (oe && exp_q.size() > 0 && $rose(oe)) begin
			exp_v = exp_q.pop_front();
			`CHK(dout, exp_v)
		end
		if (oe2 && exp2_q.size() > 0 && $rose(oe2)) begin
			exp2_v = exp2_q.pop_front();
			`CHK(dout2, exp2_v)
		end
	end
	initial begin
		#150000;
		n_fail++;
		conclude();
	end
	initial begin
		{rst_n, trig, stby, host_d, bus} = {1'b0, 1'b1, 1'b0, 8'h00, 4'hE};
		tick(20);
		rst_n = 1'b1;
		tick(3);
		`CHK({pwr, thn, oe}, 3'b110)
		conv(1'b0);
		conv(1'b1);
		repeat (3) conv(1'b0);
		repeat (4) begin
			lo = 8'($random(seed)) & 8'hFE;
			hi = 8'($random(seed));
			acc(1'b1, 1'b0, lo);
			acc(1'b1, 1'b1, hi);
			`CHK(ctrl, {4'h0, hi[3:0], lo})
		end
		`CHK(shadow, 16'h0000)
		// Low bit 0 set in a control word routes the following word to the shadow register.
		lo = 8'($random(seed)) | 8'h01;
		hi = 8'($random(seed));
		acc(1'b1, 1'b0, lo);
		acc(1'b1, 1'b1, hi);
		`CHK(ctrl, {4'h0, hi[3:0], lo})
		acc(1'b1, 1'b0, ~lo);
		acc(1'b1, 1'b1, ~hi);
		`CHK(shadow, {4'h0, ~hi[3:0], ~lo})
		`CHK(ctrl, {4'h0, hi[3:0], lo})
		`CHK({ctrl2, shadow2}, {ctrl, shadow})
		stby = 1'b1;
		tick(4);
		`CHK(pwr, 1'b0)
		stby = 1'b0;
		conv(1'b0);
		`CHK(pwr, 1'b1)
		`CHK(exp_q.size(), 0)
		`CHK(exp2_q.size(), 0)
		conclude();
	end
endmodule // acb_port_bench
